// ### rtl/io_ports.v
`timescale 1ns/1ps
`default_nettype none
`include "io_ports_defines.vh"

module io_ports #(
  parameter ADDR_W = 8
) (
  input  wire              clk_i,
  input  wire              rst_i,
  // classic wishbone slave
  input  wire              cyc_i,
  input  wire              stb_i,
  input  wire              we_i,
  input  wire [ADDR_W-1:0] adr_i,
  input  wire [3:0]        sel_i,
  input  wire [31:0]       dat_i,
  output reg  [31:0]       dat_o,
  output reg               ack_o,
  // low-voltage port a pins
  input  wire [7:0]        port_a_in_i,
  output reg  [7:0]        port_a_out_o,
  output reg  [7:0]        port_a_oe_n_o,
  output reg  [7:0]        port_a_pullup_o,
  // low-voltage port b pins
  input  wire [7:0]        port_b_in_i,
  output reg  [7:0]        port_b_out_o,
  output reg  [7:0]        port_b_oe_n_o,
  output reg  [7:0]        port_b_pullup_o,
  // high-voltage pins
  output reg  [7:0]        hv_output_port_a_o,
  output reg  [7:0]        hv_output_port_b_o,
  input  wire [7:0]        hv_io_port_a_in_i,
  output reg  [7:0]        hv_io_port_a_out_o,
  output reg  [7:0]        hv_io_port_a_oe_n_o,
  input  wire [4:0]        hv_io_port_b_in_i,
  output reg  [4:0]        hv_io_port_b_out_o,
  output reg  [4:0]        hv_io_port_b_oe_n_o,
  // display controller drive lines 24..52
  input  wire [28:0]       display_line_i,
  // peripherals
  input  wire              buzzer_output_i,
  input  wire              pulse_width_output_i,
  input  wire              serial3_clock_out_i,
  input  wire              serial3_clock_oe_i,
  input  wire              serial3_data_out_i,
  input  wire              serial1_data_out_i,
  input  wire              serial1_clock_out_i,
  input  wire              serial1_clock_oe_i,
  input  wire              serial_enable_i,
  output reg               ext_irq0_input_o,
  output reg               ext_irq1_input_o,
  output reg               remote_timer_input_o,
  output reg  [6:0]        analog_in_o,
  output reg               serial3_clock_in_o,
  output reg               serial1_data_in_o,
  output reg               serial1_clock_in_o,
  output reg               event_counter_input_o
);

  reg  [7:0] port_a_data_reg;
  reg  [7:0] port_a_direction_reg;
  reg  [7:0] port_b_data_reg;
  reg  [7:0] port_b_direction_reg;
  reg  [7:0] hv_out_a_reg;
  reg  [7:0] hv_out_b_reg;
  reg  [7:0] hv_io_a_reg;
  reg  [4:0] hv_io_b_reg;
  reg  [7:0] pin_function_select_reg;
  reg  [7:0] pullup_a_reg;
  reg  [7:0] pullup_b_reg;
  reg  [7:0] claim_out_a_reg;
  reg  [7:0] claim_out_b_reg;
  reg  [7:0] claim_io_a_reg;
  reg  [4:0] claim_io_b_reg;
  reg  [7:0] rd_byte;
  wire       req;
  wire       wr;
  wire [7:0] wbyte;

  // register map in brief, byte lane 0 only:
  //   C0  port a data      latch on write, pin or latch on read
  //   C1  port a direction write only, reads zero
  //   C4  port b data      latch on write, pin or latch on read
  //   C5  port b direction write only, reads zero
  //   C6  hv output a      latch, reads back the latch
  //   C8  hv output b      latch, reads back the latch
  //   CA  hv io a          latch on write, pin level on read
  //   CC  hv io b          five bits, latch on write, pin level on read
  //   F4  function select  write only, bits 7 to 5 stored as zero
  //   FC  pull-up a        read and write
  //   FE  pull-up b        read and write
  //   D8  display claim for hv output a
  //   D9  display claim for hv output b
  //   DA  display claim for hv io a
  //   DB  display claim for hv io b
  //
  // pin conventions:
  //   every *_oe_n_o bit is low while this block drives the pin,
  //   high while the pin is left to the outside world.
  //   every pin output is registered, so a register write shows
  //   on the pins one clock after the bus stores it.
  //   the alternate inputs handed to peripherals are registered too,
  //   one clock behind the pin level.
  //
  // hazards and limits a user should know:
  //   a read of a write-only place returns zero, never the stored value,
  //   so a read-modify-write on such a place destroys its contents.
  //   a high hv io latch drives the pin high, so reading the pin level
  //   back only makes sense once software has cleared the latch.
  //   selecting the event input releases hv io b bit 3 even over a display
  //   claim on that bit, so neither the latch nor line 51 can fight an external
  //   source; software need not touch line 51 while counting events.
  //   the serial enable input overrides the port b direction register
  //   for the serial pins; direction bits there take effect again once
  //   the serial block lets go.
  //   unmapped addresses are still acknowledged so that a stray access
  //   never hangs the bus; writes there are dropped.
  //
  // trade-off: the pin drive is registered rather than combinational,
  // which costs one clock of latency but keeps the pins free of glitches
  // while the select and direction registers change.

  // pin level where a bit is an input, latch where it drives
  function [7:0] port_read;
    input [7:0] latch;
    input [7:0] dir;
    input [7:0] pin;
    begin
      port_read = (latch & dir) | (pin & ~dir);
    end
  endfunction

  // claim mask picks the display line over the port latch, bit by bit
  function [7:0] claim_mux;
    input [7:0] line;
    input [7:0] latch;
    input [7:0] claim;
    begin
      claim_mux = (line & claim) | (latch & ~claim);
    end
  endfunction

  // lane 0 carries the byte; a single-bit cpu operation arrives as a byte write
  assign req   = cyc_i & stb_i & ~ack_o;
  assign wr    = req & we_i & sel_i[0];
  assign wbyte = dat_i[7:0];

  // register writes; every data register but hv io b takes any byte value
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_a_data_reg         <= `RESET_BYTE;
      port_a_direction_reg    <= `RESET_BYTE;
      port_b_data_reg         <= `RESET_BYTE;
      port_b_direction_reg    <= `RESET_BYTE;
      hv_out_a_reg            <= `RESET_BYTE;
      hv_out_b_reg            <= `RESET_BYTE;
      hv_io_a_reg             <= `RESET_BYTE; // latch low releases the pin
      hv_io_b_reg             <= `RESET_HV6;
      pin_function_select_reg <= `RESET_BYTE;
      pullup_a_reg            <= `RESET_BYTE;
      pullup_b_reg            <= `RESET_BYTE;
      claim_out_a_reg         <= `RESET_BYTE;
      claim_out_b_reg         <= `RESET_BYTE;
      claim_io_a_reg          <= `RESET_BYTE;
      claim_io_b_reg          <= `RESET_HV6;
    end else if (wr) begin
      case (adr_i[7:0])
        `PORT_A_DATA_ADDR:       port_a_data_reg <= wbyte;
        `PORT_A_DIR_ADDR:        port_a_direction_reg <= wbyte;
        `PORT_B_DATA_ADDR:       port_b_data_reg <= wbyte;
        `PORT_B_DIR_ADDR:        port_b_direction_reg <= wbyte;
        `HV_OUT_A_ADDR:          hv_out_a_reg <= wbyte;
        `HV_OUT_B_ADDR:          hv_out_b_reg <= wbyte;
        `HV_IO_A_ADDR:           hv_io_a_reg <= wbyte;
        `HV_IO_B_ADDR:           hv_io_b_reg <= wbyte[4:0];
        `PIN_FUNC_SEL_ADDR:      pin_function_select_reg <= wbyte & `SEL_MASK;
        `PULLUP_A_ADDR:          pullup_a_reg <= wbyte;
        `PULLUP_B_ADDR:          pullup_b_reg <= wbyte;
        `DISP_CLAIM_HV_A_ADDR:   claim_out_a_reg <= wbyte;
        `DISP_CLAIM_HV_B_ADDR:   claim_out_b_reg <= wbyte;
        `DISP_CLAIM_HV_IOA_ADDR: claim_io_a_reg <= wbyte;
        `DISP_CLAIM_HV_IOB_ADDR: claim_io_b_reg <= wbyte[4:0];
        default: ;
      endcase
    end
  end

  // read mux: data registers return pin level on inputs, latch on outputs;
  // write-only registers read zero so software cannot rely on them
  always @* begin
    case (adr_i[7:0])
      `PORT_A_DATA_ADDR:
        rd_byte = port_read(port_a_data_reg, port_a_direction_reg, port_a_in_i);
      `PORT_B_DATA_ADDR:
        rd_byte = port_read(port_b_data_reg, port_b_direction_reg, port_b_in_i);
      `HV_OUT_A_ADDR:          rd_byte = hv_out_a_reg;
      `HV_OUT_B_ADDR:          rd_byte = hv_out_b_reg;
      // pin level seen; a high latch pulls the pin, hence software clears it
      `HV_IO_A_ADDR:           rd_byte = hv_io_port_a_in_i;
      `HV_IO_B_ADDR:           rd_byte = {3'b000, hv_io_port_b_in_i};
      `PULLUP_A_ADDR:          rd_byte = pullup_a_reg;
      `PULLUP_B_ADDR:          rd_byte = pullup_b_reg;
      `DISP_CLAIM_HV_A_ADDR:   rd_byte = claim_out_a_reg;
      `DISP_CLAIM_HV_B_ADDR:   rd_byte = claim_out_b_reg;
      `DISP_CLAIM_HV_IOA_ADDR: rd_byte = claim_io_a_reg;
      `DISP_CLAIM_HV_IOB_ADDR: rd_byte = {3'b000, claim_io_b_reg};
      default:                 rd_byte = 8'h00;
    endcase
  end

  // one-wait-state answer; unmapped addresses still ack and read zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req;
      if (req && !we_i)
        dat_o <= {24'h000000, rd_byte};
    end
  end

  // low-voltage pin drive, registered so pins never glitch
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_a_out_o    <= 8'h00;
      port_a_oe_n_o   <= 8'hFF;
      port_a_pullup_o <= 8'h00;
      port_b_out_o    <= 8'h00;
      port_b_oe_n_o   <= 8'hFF;
      port_b_pullup_o <= 8'h00;
    end else begin
      port_a_out_o  <= port_a_data_reg;
      port_a_oe_n_o <= ~port_a_direction_reg;
      // buzzer selected drives regardless of direction
      if (pin_function_select_reg[`SEL_BUZZER_BIT]) begin
        port_a_out_o[7]  <= buzzer_output_i;
        port_a_oe_n_o[7] <= 1'b0;
      end
      // interrupt pins forced to input when selected
      if (pin_function_select_reg[`SEL_IRQ0_BIT])
        port_a_oe_n_o[0] <= 1'b1;
      if (pin_function_select_reg[`SEL_IRQ1_BIT])
        port_a_oe_n_o[1] <= 1'b1;
      port_a_pullup_o <= pullup_a_reg & ~port_a_direction_reg;
      port_b_out_o  <= port_b_data_reg;
      port_b_oe_n_o <= ~port_b_direction_reg;
      // serial lines take over when the serial block is enabled
      if (serial_enable_i) begin
        port_b_out_o[0]  <= serial3_clock_out_i;
        port_b_oe_n_o[0] <= ~serial3_clock_oe_i;
        port_b_out_o[1]  <= serial3_data_out_i;
        port_b_oe_n_o[1] <= 1'b0;
        port_b_out_o[5]  <= serial1_data_out_i;
        port_b_oe_n_o[5] <= 1'b0;
        port_b_oe_n_o[6] <= 1'b1;
        port_b_out_o[7]  <= serial1_clock_out_i;
        port_b_oe_n_o[7] <= ~serial1_clock_oe_i;
      end
      port_b_pullup_o <= pullup_b_reg & ~port_b_direction_reg;
    end
  end

  // high-voltage drive: display claim wins over the port latch
  always @(posedge clk_i) begin
    if (rst_i) begin
      hv_output_port_a_o  <= 8'h00;
      hv_output_port_b_o  <= 8'h00;
      hv_io_port_a_out_o  <= 8'h00;
      hv_io_port_a_oe_n_o <= 8'hFF;
      hv_io_port_b_out_o  <= 5'h00;
      hv_io_port_b_oe_n_o <= 5'h1F;
    end else begin
      hv_output_port_a_o <= claim_mux(display_line_i[7:0], hv_out_a_reg,
                                      claim_out_a_reg);
      hv_output_port_b_o <= claim_mux(display_line_i[15:8], hv_out_b_reg,
                                      claim_out_b_reg);
      // open-drain style: a latch one drives, a zero releases for input
      hv_io_port_a_out_o  <= claim_mux(display_line_i[23:16], hv_io_a_reg,
                                       claim_io_a_reg);
      hv_io_port_a_oe_n_o <= ~(claim_io_a_reg | hv_io_a_reg);
      hv_io_port_b_out_o  <= (display_line_i[28:24] & claim_io_b_reg) |
                             (hv_io_b_reg & ~claim_io_b_reg);
      hv_io_port_b_oe_n_o <= ~(claim_io_b_reg | hv_io_b_reg);
      // pwm drives bit 4 when selected
      if (pin_function_select_reg[`SEL_PWM_BIT]) begin
        hv_io_port_b_out_o[4]  <= pulse_width_output_i;
        hv_io_port_b_oe_n_o[4] <= 1'b0;
      end
      // event input keeps bit 3 released over the latch, the claim and line 51
      if (pin_function_select_reg[`SEL_EVENT_BIT]) begin
        hv_io_port_b_out_o[3]  <= 1'b0;
        hv_io_port_b_oe_n_o[3] <= 1'b1;
      end
    end
  end

  // alternate inputs to peripherals, gated by selection where one exists
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_irq0_input_o      <= 1'b0;
      ext_irq1_input_o      <= 1'b0;
      remote_timer_input_o  <= 1'b0;
      analog_in_o           <= 7'h00;
      serial3_clock_in_o    <= 1'b0;
      serial1_data_in_o     <= 1'b0;
      serial1_clock_in_o    <= 1'b0;
      event_counter_input_o <= 1'b0;
    end else begin
      ext_irq0_input_o     <= pin_function_select_reg[`SEL_IRQ0_BIT] & port_a_in_i[0];
      ext_irq1_input_o     <= pin_function_select_reg[`SEL_IRQ1_BIT] & port_a_in_i[1];
      remote_timer_input_o <= port_a_in_i[2];
      analog_in_o          <= {port_b_in_i[4:2], port_a_in_i[6:3]};
      serial3_clock_in_o   <= port_b_in_i[0];
      serial1_data_in_o    <= port_b_in_i[6];
      serial1_clock_in_o   <= port_b_in_i[7];
      event_counter_input_o <= pin_function_select_reg[`SEL_EVENT_BIT] &
                               hv_io_port_b_in_i[3];
    end
  end

endmodule // io_ports
`default_nettype wire

// ### rtl/io_ports_defines.vh
`ifndef IO_PORTS_DEFINES_VH
`define IO_PORTS_DEFINES_VH
// register byte offsets
`define PORT_A_DATA_ADDR      8'hC0
`define PORT_A_DIR_ADDR       8'hC1
`define PORT_B_DATA_ADDR      8'hC4
`define PORT_B_DIR_ADDR       8'hC5
`define HV_OUT_A_ADDR         8'hC6
`define HV_OUT_B_ADDR         8'hC8
`define HV_IO_A_ADDR          8'hCA
`define HV_IO_B_ADDR          8'hCC
`define PIN_FUNC_SEL_ADDR     8'hF4
`define PULLUP_A_ADDR         8'hFC
`define PULLUP_B_ADDR         8'hFE
`define DISP_CLAIM_HV_A_ADDR  8'hD8
`define DISP_CLAIM_HV_B_ADDR  8'hD9
`define DISP_CLAIM_HV_IOA_ADDR 8'hDA
`define DISP_CLAIM_HV_IOB_ADDR 8'hDB
// pin function select fields
`define SEL_IRQ0_BIT          0
`define SEL_IRQ1_BIT          1
`define SEL_BUZZER_BIT        2
`define SEL_EVENT_BIT         3
`define SEL_PWM_BIT           4
`define SEL_MASK              8'h1F
// reset values
`define RESET_BYTE            8'h00
`define RESET_HV6             5'h00
`endif

// ### verification/io_ports_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// watches the bus answer and the pin enables of io_ports
module io_ports_asserts #(
  parameter ADDR_W = 8
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0]        sel_i,
  input wire logic [31:0]       dat_i,
  input wire logic [31:0]       dat_o,
  input wire logic              ack_o,
  input wire logic [7:0]        port_a_oe_n_o,
  input wire logic [7:0]        port_a_pullup_o,
  input wire logic [7:0]        port_b_oe_n_o,
  input wire logic [7:0]        hv_io_port_a_oe_n_o,
  input wire logic [4:0]        hv_io_port_b_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take = cyc_i && stb_i && !ack_o;
  // reset values are seen at the first edge after release
  property p_rst_dir;
    $fell(rst_i) |-> port_a_oe_n_o == 8'hFF && port_b_oe_n_o == 8'hFF;
  endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("lv pins not inputs");
  property p_rst_hv;
    $fell(rst_i) |-> hv_io_port_a_oe_n_o == 8'hFF && hv_io_port_b_oe_n_o == 5'h1F;
  endproperty
  a_rst_hv: assert property (p_rst_hv) else $error("hv pins not inputs");
  property p_ack;
    take |=> ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_ack_one;
    ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_rd_hi;
    ack_o |-> dat_o[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read lanes set");
  // write-only places answer zero
  property p_wo_read;
    take && !we_i && (adr_i == 8'hC1 || adr_i == 8'hC5 || adr_i == 8'hF4) |=> dat_o == 32'h0;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only read nonzero");
  // bits 6:2 have no forced function, so direction alone decides them
  property p_dir;
    take && we_i && sel_i[0] && adr_i == 8'hC1 |=> ##1
      port_a_oe_n_o[6:2] == ~$past(dat_i[6:2], 2);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_pull;
    (port_a_pullup_o & ~port_a_oe_n_o) == 8'h00;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up on driven pin");
endmodule // io_ports_asserts
bind io_ports io_ports_asserts #(.ADDR_W(ADDR_W)) io_ports_asserts_i (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .port_a_oe_n_o(port_a_oe_n_o),
  .port_a_pullup_o(port_a_pullup_o), .port_b_oe_n_o(port_b_oe_n_o),
  .hv_io_port_a_oe_n_o(hv_io_port_a_oe_n_o), .hv_io_port_b_oe_n_o(hv_io_port_b_oe_n_o));
`default_nettype wire

// ### verification/io_ports_bench.sv
`timescale 1ns/1ps
`default_nettype none
module io_ports_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dw = 32'h0;
  logic [8:0]  per = 9'h000;
  logic [28:0] disp = 29'h0;
  // load levels: port a [7:0], port b [15:8], hv io a [23:16], hv io b [28:24]
  logic [28:0] ext_v = {5'h0A, 8'h96, 8'h3C, 8'hA5};
  // load enables per pin, same packing; a cleared bit leaves the pin to its pull-up, or floating where no pull-up is on
  logic [28:0] ext_en = 29'h1FFFFFFF;
  // hv io pins carry no pull-up
  logic [12:0] hv_pu = 13'h0000;
  int          miscompares = 0;
  int          n_compared = 0;
  wire logic [31:0] dr;
  wire logic        ack, irq0, irq1, rtim, s3c, s1d, s1c, ev;
  wire logic [6:0]  an;
  wire logic [7:0]  a_out, a_oe, a_pu, a_pin, b_out, b_oe, b_pu, b_pin;
  wire logic [7:0]  hv3, hv4, h5_out, h5_oe, h5_pin;
  wire logic [4:0]  h6_out, h6_oe, h6_pin;
  io_ports io_ports_i (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dw), .dat_o(dr), .ack_o(ack),
    .port_a_in_i(a_pin), .port_a_out_o(a_out), .port_a_oe_n_o(a_oe), .port_a_pullup_o(a_pu),
    .port_b_in_i(b_pin), .port_b_out_o(b_out), .port_b_oe_n_o(b_oe), .port_b_pullup_o(b_pu),
    .hv_output_port_a_o(hv3), .hv_output_port_b_o(hv4), .hv_io_port_a_in_i(h5_pin),
    .hv_io_port_a_out_o(h5_out), .hv_io_port_a_oe_n_o(h5_oe), .hv_io_port_b_in_i(h6_pin),
    .hv_io_port_b_out_o(h6_out), .hv_io_port_b_oe_n_o(h6_oe), .display_line_i(disp),
    .buzzer_output_i(per[0]), .pulse_width_output_i(per[1]), .serial3_clock_out_i(per[2]),
    .serial3_clock_oe_i(per[3]), .serial3_data_out_i(per[4]), .serial1_data_out_i(per[5]),
    .serial1_clock_out_i(per[6]), .serial1_clock_oe_i(per[7]), .serial_enable_i(per[8]),
    .ext_irq0_input_o(irq0), .ext_irq1_input_o(irq1), .remote_timer_input_o(rtim),
    .analog_in_o(an), .serial3_clock_in_o(s3c), .serial1_data_in_o(s1d),
    .serial1_clock_in_o(s1c), .event_counter_input_o(ev));
  // hv io ports have no pull-up
  io_ports_pins #(.W(8)) pa (.clk_i(clk), .out_i(a_out), .oe_n_i(a_oe), .pullup_i(a_pu),
    .ext_val_i(ext_v[7:0]), .ext_en_i(ext_en[7:0]), .pin_o(a_pin));
  io_ports_pins #(.W(8)) pb (.clk_i(clk), .out_i(b_out), .oe_n_i(b_oe), .pullup_i(b_pu),
    .ext_val_i(ext_v[15:8]), .ext_en_i(ext_en[15:8]), .pin_o(b_pin));
  io_ports_pins #(.W(8)) p5 (.clk_i(clk), .out_i(h5_out), .oe_n_i(h5_oe),
    .pullup_i(hv_pu[7:0]), .ext_val_i(ext_v[23:16]), .ext_en_i(ext_en[23:16]), .pin_o(h5_pin));
  io_ports_pins #(.W(5)) p6 (.clk_i(clk), .out_i(h6_out), .oe_n_i(h6_oe),
    .pullup_i(hv_pu[12:8]), .ext_val_i(ext_v[28:24]), .ext_en_i(ext_en[28:24]), .pin_o(h6_pin));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; request held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dw <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, {24'h0, e}, q);
  endtask
  // pin inputs reach the peripheral outputs through a register
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("hv6 oe_n", 32'h1F, h6_oe);
    rdc("a pins", 8'hC0, 8'hA5);
    rdc("a dir", 8'hC1, 8'h00);
    rdc("select", 8'hF4, 8'h00);
    rdc("unmapped", 8'hC2, 8'h00);
    wr(8'hC1, 8'h55);
    wr(8'hC0, 8'hFF);
    chk("a oe_n", 32'hAA, a_oe);
    rdc("a mixed", 8'hC0, 8'hF5);
    settle();
    chk("timer,analog", 32'h0FE, {rtim, an});
    wr(8'hFC, 8'h0F);
    chk("a pullup", 32'h0A, a_pu);
    ext_en[7:0] <= 8'hFD;
    rdc("a pulled pin", 8'hC0, 8'hF7);
    ext_en <= 29'h1FFFFFFF;
    wr(8'hC5, 8'hF0);
    wr(8'hC4, 8'hC1);
    chk("b oe_n", 32'h0F, b_oe);
    chk("b pins", 32'hCC, b_pin);
    wr(8'hC6, 8'h5A);
    chk("hv out a", 32'h5A, hv3);
    wr(8'hC8, 8'hC3);
    chk("hv out b pins", 32'hC3, hv4);
    rdc("hv out b", 8'hC8, 8'hC3);
    wr(8'hCA, 8'h0F);
    chk("hv io a oe_n", 32'hF0, h5_oe);
    chk("hv io a out", 32'h0F, h5_out);
    wr(8'hCA, 8'h00);
    rdc("hv io a pins", 8'hCA, 8'h96);
    disp <= {5'h10, 16'h0000, 8'h3C};
    wr(8'hD8, 8'hFF);
    chk("claimed hv", 32'h3C, hv3);
    per <= 9'h003;
    wr(8'hF4, 8'h1F);
    settle();
    chk("a7 a0 oe_n", 32'h1, {a_oe[7], a_oe[0]});
    chk("buzzer pin", 32'h1, a_pin[7]);
    chk("irq1 irq0", 32'h1, {irq1, irq0});
    chk("hv b oe_n 4:3", 32'h1, h6_oe[4:3]);
    chk("pwm,event", 32'h3, {h6_pin[4], ev});
    rdc("select rd", 8'hF4, 8'h00);
    per <= 9'h113;
    settle();
    chk("serial3 out", 32'h1, b_out[1]);
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule // io_ports_bench
`default_nettype wire

// ### verification/io_ports_pins.sv
`timescale 1ns/1ps
`default_nettype none
// pin loads: an external driver, a pull-up, or a floating pin
module io_ports_pins #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] oe_n_i,
  input  wire logic [W-1:0] pullup_i,
  input  wire logic [W-1:0] ext_val_i,
  input  wire logic [W-1:0] ext_en_i,
  output var  logic [W-1:0] pin_o
);
  logic [W-1:0] float_q = '0;
  // a floating pin flips every cycle so a stale level never reads as valid
  always @(posedge clk_i) float_q <= ~float_q;
  // design drive wins, then the load, then the pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!oe_n_i[i]) pin_o[i] = out_i[i];
      else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
      else if (pullup_i[i]) pin_o[i] = 1'b1;
      else pin_o[i] = float_q[i];
    end
  end
endmodule // io_ports_pins
`default_nettype wire
